// [logic/mfj_forced_jump.sv]
// monitor forced-jump logic: return sequencer, saved address, interrupt request
`default_nettype none
module mfj_forced_jump
  import mfj_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CE,
  input wire logic [14:0] ADDRESS,
  input wire logic [7:0] DATA_IN,
  output logic [7:0] DATA_OUT,
  output logic DATA_OE,
  input wire logic OPERATION_REQUEST,
  input wire logic MEMORY_IO,
  input wire logic WRITE,
  input wire logic EXTENDED_IO,
  input wire logic INTERRUPT_ACKNOWLEDGE,
  input wire logic WRITE_CONTROL_OP,
  output logic MEMORY_INHIBIT,
  output logic INTERRUPT_REQUEST_INPUT,
  output logic PROCESSOR_RESET_REQUEST,
  input wire logic MONITOR_KEY,
  input wire logic INTERRUPT_KEY,
  input wire logic LINE_CLOCK,
  input wire logic BUS_INTERRUPT,
  input wire logic SOURCE_SELECT,
  input wire logic BUS_INTERRUPT_ENABLE,
  input wire logic DIRECT_SELECT
);
  // pin synchronisers, bit order:
  // 6 direct, 5 bus enable, 4 source, 3 bus int, 2 line clk, 1 int key, 0 mon key
  localparam int SYNC_WIDTH = 7;
  logic [SYNC_WIDTH-1:0] pins;
  logic [SYNC_WIDTH-1:0] sync1_reg;
  logic [SYNC_WIDTH-1:0] sync2_reg;
  logic monitor_prev_reg; // edge detect on the synced key
  logic source_prev_reg; // edge detect on the chosen source
  logic request_prev_reg; // previous operation request level
  mfj_seq_type state_reg; // sequencer mode
  logic [4:0] count_reg; // sequencer counter
  logic [1:0] irq_step_reg; // position inside an interrupt sequence
  logic irq_direct_reg; // direct/indirect latched at acknowledge
  logic por_reg; // armed by reset, allows the address-zero no-op
  logic hold_reg; // this request is answered by the block
  logic [7:0] data_reg; // byte answered for this request
  logic irq_flop_reg; // interrupt request flop
  logic [14:0] saved; // last-address register value
  logic [7:0] table_data; // lookup table output
  logic [4:0] table_index; // lookup table address
  logic start; // first cycle of an operation request
  logic mem_read; // memory read request
  logic io_read; // extended i/o read request
  logic count_load; // write to the counter load port
  logic monitor_press; // monitor key pressed
  logic source_level; // selected interrupt source
  logic source_rise; // new interrupt event
  logic live; // counter sits in the driven part
  logic drive_now; // this request gets table bytes
  logic read_high; // monitor reads the saved high byte

  assign pins = {DIRECT_SELECT, BUS_INTERRUPT_ENABLE, SOURCE_SELECT, BUS_INTERRUPT,
                 LINE_CLOCK, INTERRUPT_KEY, MONITOR_KEY};

  // two flops per pin; the first stage feeds only the second
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_WIDTH; gi++)
    begin : g_sync
      always_ff @(posedge CLK)
      begin
        if (RESET)
        begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
        end
        else if (CE)
        begin
          sync1_reg[gi] <= pins[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  // request decode, all on the processor clock
  assign start = OPERATION_REQUEST && !request_prev_reg;
  assign mem_read = start && MEMORY_IO && !WRITE;
  assign io_read = start && !MEMORY_IO && EXTENDED_IO && !WRITE;
  assign count_load = start && !MEMORY_IO && EXTENDED_IO && WRITE
                      && ADDRESS[7:0] == PORT_SEQUENCE_COUNT_LOAD;
  assign read_high = io_read && ADDRESS[7:0] == PORT_SAVED_ADDRESS_HIGH;
  assign monitor_press = sync2_reg[0] && !monitor_prev_reg;

  // key or line clock, bus source only when its option is on
  assign source_level = (sync2_reg[4] ? sync2_reg[2] : sync2_reg[1])
                        || (sync2_reg[5] && sync2_reg[3]);
  assign source_rise = source_level && !source_prev_reg;

  // only the branch counts are live; lower counts are dummy states apart from the power-on no-op at zero, a spent count never drives
  assign live = count_reg >= SEQ_COUNT_LIVE_FIRST && count_reg <= SEQ_COUNT_LAST;

  // decide whether the table answers this fetch
  always_comb
  begin
    drive_now = 1'b0;
    if (mem_read && !INTERRUPT_ACKNOWLEDGE)
    begin
      case (state_reg)
        MFJ_COUNT: drive_now = live
          || (por_reg && count_reg == SEQ_COUNT_POWER_ON && ADDRESS == 15'h0000);
        MFJ_IRQ: drive_now = 1'b1;
        default: drive_now = 1'b0;
      endcase
    end
  end

  // in an interrupt sequence, latched direct select and step become table address bits
  assign table_index = (state_reg == MFJ_IRQ)
                       ? {SEQ_IRQ_PAGE, irq_direct_reg, irq_step_reg}
                       : count_reg;

  mfj_branch_table u_table
  (
    .index(table_index),
    .data(table_data)
  );

  // saved address follows user fetches, freezes on the first forced byte
  mfj_saved_address u_saved
  (
    .clk(CLK),
    .reset(RESET),
    .ce(CE),
    .capture(start && MEMORY_IO),
    .address(ADDRESS),
    .freeze(drive_now),
    .release_hold(read_high),
    .saved(saved)
  );

  // edge detector history
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      monitor_prev_reg <= 1'b0;
      source_prev_reg <= 1'b0;
      request_prev_reg <= 1'b0;
    end
    else if (CE)
    begin
      monitor_prev_reg <= sync2_reg[0];
      source_prev_reg <= source_level;
      request_prev_reg <= OPERATION_REQUEST;
    end
  end

  // sequencer: triggers first, then loads, then advancing
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      // power-up arms the full sequence
      state_reg <= MFJ_COUNT;
      count_reg <= SEQ_COUNT_POWER_ON;
      por_reg <= 1'b1;
      irq_step_reg <= 2'b00;
      irq_direct_reg <= 1'b0;
    end
    else if (CE)
    begin
      if (monitor_press)
      begin
        // key also resets the processor, so fetch restarts at zero
        state_reg <= MFJ_COUNT;
        count_reg <= SEQ_COUNT_POWER_ON;
        por_reg <= 1'b1;
      end
      else if (WRITE_CONTROL_OP)
      begin
        // breakpoint: next fetch is not at zero, so start at the branch
        state_reg <= MFJ_COUNT;
        count_reg <= SEQ_COUNT_LIVE_FIRST;
        por_reg <= 1'b0;
      end
      else if (count_load)
      begin
        state_reg <= MFJ_COUNT;
        count_reg <= DATA_IN[4:0];
        por_reg <= 1'b0;
      end
      else if (start)
      begin
        case (state_reg)
          MFJ_COUNT:
          begin
            if (INTERRUPT_ACKNOWLEDGE)
            begin
              // the processor only acknowledges between instructions
              state_reg <= MFJ_IRQ;
              irq_step_reg <= 2'b00;
              irq_direct_reg <= sync2_reg[6];
            end
            else
            begin
              count_reg <= count_reg + 5'd1;
              if (count_reg == SEQ_COUNT_LAST)
                state_reg <= MFJ_IDLE;
            end
          end
          MFJ_IRQ:
          begin
            if (!INTERRUPT_ACKNOWLEDGE)
            begin
              irq_step_reg <= irq_step_reg + 2'd1;
              if (irq_step_reg == SEQ_IRQ_LAST_STEP)
                state_reg <= MFJ_IDLE;
            end
          end
          default: state_reg <= MFJ_IDLE;
        endcase
      end
    end
  end

  // answer byte, latched at the start of the request
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      hold_reg <= 1'b0;
      data_reg <= 8'h00;
    end
    else if (CE)
    begin
      if (start)
      begin
        hold_reg <= 1'b0;
        if (INTERRUPT_ACKNOWLEDGE)
        begin
          hold_reg <= 1'b1;
          data_reg <= sync2_reg[6] ? VECTOR_INDIRECT : VECTOR_DIRECT;
        end
        else if (io_read && ADDRESS[7:0] == PORT_SAVED_ADDRESS_LOW)
        begin
          hold_reg <= 1'b1;
          data_reg <= saved[7:0];
        end
        else if (read_high)
        begin
          hold_reg <= 1'b1;
          data_reg <= {1'b0, saved[14:8]};
        end
        else if (drive_now)
        begin
          hold_reg <= 1'b1;
          data_reg <= (por_reg && count_reg == SEQ_COUNT_POWER_ON)
                      ? OPCODE_NO_OPERATION : table_data;
        end
      end
      else if (!OPERATION_REQUEST)
        hold_reg <= 1'b0;
    end
  end

  // interrupt request flop; a new event wins over acknowledge
  always_ff @(posedge CLK)
  begin
    if (RESET)
      irq_flop_reg <= 1'b0;
    else if (CE)
    begin
      if (source_rise)
        irq_flop_reg <= 1'b1;
      else if (INTERRUPT_ACKNOWLEDGE)
        irq_flop_reg <= 1'b0;
    end
  end

  // one-cycle processor reset request on the monitor key
  always_ff @(posedge CLK)
  begin
    if (RESET)
      PROCESSOR_RESET_REQUEST <= 1'b0;
    else if (CE)
      PROCESSOR_RESET_REQUEST <= monitor_press;
  end

  // inhibit also covers the first cycle, before the byte is latched
  assign MEMORY_INHIBIT = OPERATION_REQUEST && (drive_now || (hold_reg && MEMORY_IO));
  assign DATA_OE = OPERATION_REQUEST && hold_reg;
  assign DATA_OUT = data_reg;
  assign INTERRUPT_REQUEST_INPUT = irq_flop_reg;

  // checks
  sequence s_branch_fetch;
    CE && state_reg == MFJ_COUNT && count_reg == SEQ_COUNT_LIVE_FIRST && mem_read
    && !INTERRUPT_ACKNOWLEDGE && !monitor_press && !WRITE_CONTROL_OP;
  endsequence

  sequence s_branch_answer;
    hold_reg && data_reg == OPCODE_ABSOLUTE_BRANCH_OP;
  endsequence

  property p_branch_byte;
    @(posedge CLK) disable iff (RESET) s_branch_fetch |=> s_branch_answer;
  endproperty
  a_branch_byte: assert property (p_branch_byte) else $error("branch opcode not answered");

  property p_zero_noop;
    @(posedge CLK) disable iff (RESET)
      (CE && por_reg && state_reg == MFJ_COUNT && count_reg == SEQ_COUNT_POWER_ON
       && mem_read && ADDRESS == 15'h0000 && !INTERRUPT_ACKNOWLEDGE
       && !monitor_press && !WRITE_CONTROL_OP)
      |-> MEMORY_INHIBIT ##1 (data_reg == OPCODE_NO_OPERATION && hold_reg);
  endproperty
  a_zero_noop: assert property (p_zero_noop) else $error("no-op not given at zero");

  property p_last_idle;
    @(posedge CLK) disable iff (RESET)
      (CE && state_reg == MFJ_COUNT && count_reg == SEQ_COUNT_LAST && start
       && !INTERRUPT_ACKNOWLEDGE && !count_load && !monitor_press && !WRITE_CONTROL_OP)
      |=> state_reg == MFJ_IDLE;
  endproperty
  a_last_idle: assert property (p_last_idle) else $error("sequencer did not go idle");

  property p_dummy_quiet;
    @(posedge CLK) disable iff (RESET)
      (CE && start && state_reg == MFJ_COUNT && count_reg < SEQ_COUNT_POWER_ON
       && !INTERRUPT_ACKNOWLEDGE && !io_read) |=> !hold_reg;
  endproperty
  a_dummy_quiet: assert property (p_dummy_quiet) else $error("dummy state was driven");

  property p_load;
    @(posedge CLK) disable iff (RESET)
      (CE && count_load && !monitor_press && !WRITE_CONTROL_OP)
      |=> count_reg == $past(DATA_IN[4:0]) && state_reg == MFJ_COUNT;
  endproperty
  a_load: assert property (p_load) else $error("counter load missed");

  property p_vector;
    @(posedge CLK) disable iff (RESET)
      (CE && start && INTERRUPT_ACKNOWLEDGE)
      |=> hold_reg && data_reg == ($past(sync2_reg[6]) ? VECTOR_INDIRECT : VECTOR_DIRECT);
  endproperty
  a_vector: assert property (p_vector) else $error("wrong interrupt vector");

  property p_ack_clears;
    @(posedge CLK) disable iff (RESET)
      (CE && INTERRUPT_ACKNOWLEDGE && !source_rise) |=> !INTERRUPT_REQUEST_INPUT;
  endproperty
  a_ack_clears: assert property (p_ack_clears) else $error("request not cleared");

  property p_source_sets;
    @(posedge CLK) disable iff (RESET) (CE && source_rise) |=> INTERRUPT_REQUEST_INPUT;
  endproperty
  a_source_sets: assert property (p_source_sets) else $error("request not set");

  property p_breakpoint;
    @(posedge CLK) disable iff (RESET)
      (CE && WRITE_CONTROL_OP && !monitor_press)
      |=> state_reg == MFJ_COUNT && count_reg == SEQ_COUNT_LIVE_FIRST;
  endproperty
  a_breakpoint: assert property (p_breakpoint) else $error("breakpoint did not arm");

  property p_high_byte;
    @(posedge CLK) disable iff (RESET)
      (CE && read_high && !INTERRUPT_ACKNOWLEDGE) |=> data_reg == {1'b0, $past(saved[14:8])};
  endproperty
  a_high_byte: assert property (p_high_byte) else $error("saved high byte wrong");
endmodule
`default_nettype wire

// [logic/mfj_pkg.sv]
// constants and types shared by the monitor forced-jump logic
`default_nettype none
package mfj_pkg;
  // extended i/o port numbers
  localparam logic [7:0] PORT_SEQUENCE_COUNT_LOAD = 8'hFB;
  localparam logic [7:0] PORT_SAVED_ADDRESS_LOW = 8'hFC;
  localparam logic [7:0] PORT_SAVED_ADDRESS_HIGH = 8'hFD;
  // sequencer count map
  localparam logic [4:0] SEQ_COUNT_POWER_ON = 5'h1B;
  localparam logic [4:0] SEQ_COUNT_LIVE_FIRST = 5'h1C;
  localparam logic [4:0] SEQ_COUNT_LAST = 5'h1E;
  localparam logic [4:0] SEQ_COUNT_RESET = 5'h1F;
  // interrupt sub-sequence page and last step in the table
  localparam logic [1:0] SEQ_IRQ_PAGE = 2'h1;
  localparam logic [1:0] SEQ_IRQ_LAST_STEP = 2'h2;
  // opcode bytes and monitor entry
  localparam logic [7:0] OPCODE_NO_OPERATION = 8'hC0;
  localparam logic [7:0] OPCODE_ABSOLUTE_BRANCH_OP = 8'h1F;
  localparam logic [14:0] MONITOR_ENTRY_ADDRESS = 15'h1800;
  // interrupt vectors
  localparam logic [7:0] VECTOR_DIRECT = 8'h07;
  localparam logic [7:0] VECTOR_INDIRECT = 8'h87;
  // reset value of the saved address
  localparam logic [14:0] SAVED_ADDRESS_RESET = 15'h0000;
  // sequencer modes
  typedef enum logic [1:0]
  {
    MFJ_IDLE = 2'b00,
    MFJ_COUNT = 2'b01,
    MFJ_IRQ = 2'b10
  } mfj_seq_type;
endpackage
`default_nettype wire

// [logic/mfj_branch_table.sv]
// 32 x 8 lookup table holding the branch-to-monitor bytes
`default_nettype none
module mfj_branch_table
  import mfj_pkg::*;
(
  input wire logic [4:0] index,
  output logic [7:0] data
);
  // table contents; unlisted words are dummy states and never driven
  always_comb
  begin
    case (index)
      5'h1B: data = OPCODE_NO_OPERATION;
      5'h1C: data = OPCODE_ABSOLUTE_BRANCH_OP;
      5'h1D: data = {1'b0, MONITOR_ENTRY_ADDRESS[14:8]};
      5'h1E: data = MONITOR_ENTRY_ADDRESS[7:0];
      // interrupt sequences: direct at 08, indirect at 0C
      5'h08, 5'h0C: data = OPCODE_ABSOLUTE_BRANCH_OP;
      5'h09, 5'h0D: data = {1'b0, MONITOR_ENTRY_ADDRESS[14:8]};
      5'h0A, 5'h0E: data = MONITOR_ENTRY_ADDRESS[7:0];
      default: data = 8'h00;
    endcase
  end
endmodule
`default_nettype wire

// [logic/mfj_saved_address.sv]
// last-address register with capture, freeze and release
`default_nettype none
module mfj_saved_address
  import mfj_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic capture,
  input wire logic [14:0] address,
  input wire logic freeze,
  input wire logic release_hold,
  output logic [14:0] saved
);
  logic frozen_reg; // held until the monitor reads the high byte

  // freeze flag; a new freeze wins over a release in the same cycle
  always_ff @(posedge clk)
  begin
    if (reset)
      frozen_reg <= 1'b0;
    else if (ce)
    begin
      if (freeze)
        frozen_reg <= 1'b1;
      else if (release_hold)
        frozen_reg <= 1'b0;
    end
  end

  // tracks every user address until frozen
  always_ff @(posedge clk)
  begin
    if (reset)
      saved <= SAVED_ADDRESS_RESET;
    else if (ce && capture && !frozen_reg)
      saved <= address;
  end
endmodule
`default_nettype wire

// [test/mfj_cpu_model.sv]
// processor-side bus model issuing operation requests to the forced-jump block
`default_nettype none
module mfj_cpu_model
  import mfj_pkg::*;
(
  input wire logic CLK,
  input wire logic [7:0] DATA_OUT,
  input wire logic DATA_OE,
  input wire logic MEMORY_INHIBIT,
  output var logic [14:0] ADDRESS,
  output var logic [7:0] DATA_IN,
  output var logic OPERATION_REQUEST,
  output var logic MEMORY_IO,
  output var logic WRITE,
  output var logic EXTENDED_IO,
  output var logic INTERRUPT_ACKNOWLEDGE
);
  timeunit 1ns;
  timeprecision 100ps;
  // one finished transfer, with what was seen on it
  event done;
  logic seen_inh;
  logic seen_oe;
  logic [7:0] seen_data;
  // bus idle at time zero
  initial
  begin
    ADDRESS = 15'h0000;
    DATA_IN = 8'h5a;
    OPERATION_REQUEST = 1'b0;
    MEMORY_IO = 1'b1;
    WRITE = 1'b0;
    EXTENDED_IO = 1'b0;
    INTERRUPT_ACKNOWLEDGE = 1'b0;
  end
  // one whole operation; acknowledge only ever starts between operations
  task automatic op(input logic [14:0] a, input logic m, w, x, k, input logic [7:0] d);
    @(posedge CLK);
    #1;
    ADDRESS = a;
    MEMORY_IO = m;
    WRITE = w;
    EXTENDED_IO = x;
    INTERRUPT_ACKNOWLEDGE = k;
    // a read inverts the data lines again, so right after a write it shows the last written value
    DATA_IN = w ? d : ~DATA_IN;
    OPERATION_REQUEST = 1'b1;
    #1;
    seen_inh = MEMORY_INHIBIT;
    repeat (2) @(posedge CLK);
    #1;
    seen_oe = DATA_OE;
    seen_data = DATA_OUT;
    // prompt or slow release
    repeat ($urandom_range(2, 0)) @(posedge CLK);
    @(posedge CLK);
    #1;
    OPERATION_REQUEST = 1'b0;
    INTERRUPT_ACKNOWLEDGE = 1'b0;
    DATA_IN = ~DATA_IN;
    -> done;
  endtask
endmodule
`default_nettype wire

// [test/mfj_forced_jump_tb.sv]
// self-checking bench for the monitor forced-jump logic
`default_nettype none
module mfj_forced_jump_tb
  import mfj_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, reset, wco, monitor_key, int_key, line_clk, bus_int, src_sel, bus_en, dsel;
  logic [14:0] addr;
  logic [7:0] din, dout;
  logic oe, op_req, mem_io, wr, ext_io, ack, inhibit, irq, rst_req;
  int n_mismatch, compares, n;
  // note: care-inhibit, inhibit, drive, byte
  logic [10:0] exp_q[$];
  logic [10:0] e;
  logic [14:0] a_brk;
  mfj_forced_jump mfj_forced_jump_inst (.CLK(clk), .RESET(reset), .CE(1'b1), .ADDRESS(addr),
    .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(oe), .OPERATION_REQUEST(op_req), .MEMORY_IO(mem_io),
    .WRITE(wr), .EXTENDED_IO(ext_io), .INTERRUPT_ACKNOWLEDGE(ack), .WRITE_CONTROL_OP(wco),
    .MEMORY_INHIBIT(inhibit), .INTERRUPT_REQUEST_INPUT(irq), .PROCESSOR_RESET_REQUEST(rst_req),
    .MONITOR_KEY(monitor_key), .INTERRUPT_KEY(int_key), .LINE_CLOCK(line_clk),
    .BUS_INTERRUPT(bus_int), .SOURCE_SELECT(src_sel), .BUS_INTERRUPT_ENABLE(bus_en),
    .DIRECT_SELECT(dsel));
  mfj_cpu_model mfj_cpu_model_inst (.CLK(clk), .DATA_OUT(dout), .DATA_OE(oe),
    .MEMORY_INHIBIT(inhibit), .ADDRESS(addr), .DATA_IN(din), .OPERATION_REQUEST(op_req),
    .MEMORY_IO(mem_io), .WRITE(wr), .EXTENDED_IO(ext_io), .INTERRUPT_ACKNOWLEDGE(ack));
  // 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // verdict and end of run
  task automatic results();
    if (n_mismatch == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // compare one value
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // odd user address, so a stray fetch never looks like the reset fetch
  function automatic logic [14:0] rnd();
    return 15'($urandom) | 15'h0001;
  endfunction
  // note the expectation, then run the transfer
  task automatic xfer(input logic [14:0] a, input logic m, w, x, k, input logic [7:0] d,
    input logic [10:0] ex);
    exp_q.push_back(ex);
    mfj_cpu_model_inst.op(a, m, w, x, k, d);
  endtask
  task automatic fetch(input logic [14:0] a, input logic [10:0] ex);
    xfer(a, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00, ex);
  endtask
  task automatic port(input logic [7:0] p, input logic w, input logic [7:0] d,
    input logic [10:0] ex);
    xfer({7'h00, p}, 1'b0, w, 1'b1, 1'b0, d, ex);
  endtask
  // the three forced branch bytes, then a plain fetch again
  task automatic branch_seq(input logic [14:0] a);
    fetch(a, {3'b111, OPCODE_ABSOLUTE_BRANCH_OP});
    fetch(rnd(), {3'b111, 1'b0, MONITOR_ENTRY_ADDRESS[14:8]});
    fetch(rnd(), {3'b111, MONITOR_ENTRY_ADDRESS[7:0]});
    fetch(rnd(), 11'h400);
  endtask
  // one interrupt source case; the acknowledge always gets its vector
  task automatic irq_case(input int pin, input logic sel, en, want);
    src_sel = sel;
    bus_en = en;
    dsel = 1'($urandom_range(1, 0));
    repeat (4) @(posedge clk);
    #1;
    case (pin)
      0: int_key = 1'b1;
      1: line_clk = 1'b1;
      default: bus_int = 1'b1;
    endcase
    repeat (8) @(posedge clk);
    #1;
    check({7'h00, irq}, {7'h00, want});
    int_key = 1'b0;
    line_clk = 1'b0;
    bus_int = 1'b0;
    xfer(rnd(), 1'b0, 1'b0, 1'b0, 1'b1, 8'h00,
      {3'b001, dsel ? VECTOR_INDIRECT : VECTOR_DIRECT});
    check({7'h00, irq}, 8'h00);
  endtask
  // result watcher: oldest note against what the model saw
  initial
  forever
  begin
    @(mfj_cpu_model_inst.done);
    e = exp_q.pop_front();
    if (e[10])
      check({7'h00, mfj_cpu_model_inst.seen_inh}, {7'h00, e[9]});
    check({7'h00, mfj_cpu_model_inst.seen_oe}, {7'h00, e[8]});
    if (e[8])
      check(mfj_cpu_model_inst.seen_data, e[7:0]);
  end
  // hang guard, far beyond the few hundred cycles needed
  initial
  begin
    #100000;
    n_mismatch++;
    results();
  end
  // main sequence
  initial
  begin
    void'($urandom(32'h9974_6f67));
    {reset, wco, monitor_key, int_key, line_clk, bus_int, src_sel, bus_en, dsel} = 9'h100;
    n_mismatch = 0;
    compares = 0;
    repeat (12) @(posedge clk);
    #1;
    reset = 1'b0;
    // power-on return: no-op at zero, then the branch
    fetch(15'h0000, {3'b111, OPCODE_NO_OPERATION});
    branch_seq(rnd());
    port(PORT_SAVED_ADDRESS_LOW, 1'b0, 8'h00, 11'h100);
    port(PORT_SAVED_ADDRESS_HIGH, 1'b0, 8'h00, 11'h100);
    // breakpoint return; saved address frozen at the next user fetch
    a_brk = rnd();
    fetch(rnd(), 11'h400);
    @(posedge clk);
    #1;
    wco = 1'b1;
    @(posedge clk);
    #1;
    wco = 1'b0;
    branch_seq(a_brk);
    port(PORT_SAVED_ADDRESS_LOW, 1'b0, 8'h00, {3'b001, a_brk[7:0]});
    port(PORT_SAVED_ADDRESS_HIGH, 1'b0, 8'h00, {3'b001, 1'b0, a_brk[14:8]});
    a_brk = rnd();
    fetch(a_brk, 11'h400);
    port(PORT_SAVED_ADDRESS_LOW, 1'b0, 8'h00, {3'b001, a_brk[7:0]});
    // single step over 1 to 4 requests of dummy states
    for (int s = 1; s <= 4; s++)
    begin
      port(PORT_SEQUENCE_COUNT_LOAD, 1'b1, {3'h0, SEQ_COUNT_LIVE_FIRST - 5'(s)}, 11'h000);
      repeat (s) fetch(rnd(), 11'h400);
      branch_seq(rnd());
    end
    // acknowledge while stepping picks the direct or indirect sequence
    for (int i = 0; i < 2; i++)
    begin
      dsel = i[0];
      repeat (4) @(posedge clk);
      port(PORT_SEQUENCE_COUNT_LOAD, 1'b1, {3'h0, SEQ_COUNT_LIVE_FIRST - 5'h02}, 11'h000);
      xfer(rnd(), 1'b0, 1'b0, 1'b0, 1'b1, 8'h00,
        {3'b001, i[0] ? VECTOR_INDIRECT : VECTOR_DIRECT});
      branch_seq(rnd());
    end
    // interrupt sources, enabled and not
    irq_case(0, 1'b0, 1'b0, 1'b1);
    irq_case(1, 1'b1, 1'b0, 1'b1);
    irq_case(2, 1'b0, 1'b1, 1'b1);
    irq_case(2, 1'b0, 1'b0, 1'b0);
    irq_case(1, 1'b0, 1'b0, 1'b0);
    // monitor key: one reset pulse, then the power-on return again
    monitor_key = 1'b1;
    n = 0;
    repeat (10)
    begin
      @(posedge clk);
      #1;
      n += int'(rst_req);
    end
    monitor_key = 1'b0;
    check(8'(n), 8'h01);
    fetch(15'h0000, {3'b111, OPCODE_NO_OPERATION});
    branch_seq(rnd());
    repeat (2) @(posedge clk);
    results();
  end
endmodule
`default_nettype wire
